// ---- txkmc_top.sv ----
/*
  Transmit keying and mode control top: keying, relay, oscillator
  power, receive qualification, LEDs, fault status and registers.
  Assumes one 10 MHz clock; all pin inputs except the register port are asynchronous.
*/
`timescale 1ns/10ps
module txkmc_top #(
  parameter int DEBOUNCE_CYCLES = txkmc_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tx_disable_switch,
  input wire logic panel_remote_talk_switch,
  input wire logic tone_squelch_bypass,
  input wire logic local_talk_n,
  input wire logic remote_talk_cmd,
  input wire logic carrier_detect,
  input wire logic tone_valid,
  input wire logic synth_lock,
  input wire logic [4:0] rf_fault_flags,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic serial_enable,
  input wire logic [2:0] serial_addr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic amplifier_keying,
  output logic antenna_switch_drive,
  output logic synth_osc_power,
  output logic intercom_mode,
  output logic rx_unmute,
  output logic repeat_active,
  output logic tx_led,
  output logic monitor_led,
  output logic rf_fault_status_out,
  output logic irq
);

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  logic [2:0] sw_clean;
  logic [4:0] pin_m_reg;
  logic [4:0] pin_s_reg;

  // Panel switches: sync plus debounce
  txkmc_debounce #(
    .WIDTH(3),
    .CYCLES(DEBOUNCE_CYCLES)
  ) u_debounce (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .raw({tone_squelch_bypass, panel_remote_talk_switch, tx_disable_switch}),
    .clean(sw_clean)
  );

  // Other pins: plain two-stage sync
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_m_reg <= 5'h01;
      pin_s_reg <= 5'h01;
    end else if (ce) begin
      pin_m_reg <= {synth_lock, tone_valid, carrier_detect, remote_talk_cmd, local_talk_n};
      pin_s_reg <= pin_m_reg;
    end
  end

  wire sw_dis = sw_clean[0];
  wire sw_talk = sw_clean[1];
  wire sw_mon = sw_clean[2];
  wire local_talk = ~pin_s_reg[0];
  wire rem_cmd = pin_s_reg[1];
  wire carrier = pin_s_reg[2];
  wire tone_ok = pin_s_reg[3];
  wire lock_ok = pin_s_reg[4];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0] ctrl_reg;
  logic [2:0] int_stat_reg;
  logic [2:0] int_mask_reg;
  logic [31:0] rdata_reg;
  logic [31:0] status_word;
  logic [4:0] flags_s_reg;
  logic [4:0] flags_m_reg;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire tx_disabled = sw_dis | ctrl_reg[txkmc_pkg::CTRL_SOFT_DIS];
  wire monitor = sw_mon | ctrl_reg[txkmc_pkg::CTRL_SOFT_MON];
  // Monitor drops tone need on receive only
  wire unmute_next = carrier & (tone_ok | monitor);
  // Repeat always tone qualified
  wire repeat_next = carrier & tone_ok & ctrl_reg[txkmc_pkg::CTRL_REPEAT_EN];
  // Panel switch merged with remote command
  wire remote_talk = rem_cmd | sw_talk;
  wire talk_req = local_talk | remote_talk | repeat_next;
  wire tx_req = talk_req & ~tx_disabled;

  // ----------------------------------------------------------------
  // Keying state machine
  // ----------------------------------------------------------------
  txkmc_pkg::txkmc_key_e state_reg;
  txkmc_pkg::txkmc_key_e state_next;

  // Oscillator first, key only after lock
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      txkmc_pkg::TXKMC_IDLE: begin
        if (tx_req) begin
          state_next = txkmc_pkg::TXKMC_WAIT_LOCK;
        end
      end
      txkmc_pkg::TXKMC_WAIT_LOCK: begin
        if (!tx_req) begin
          state_next = txkmc_pkg::TXKMC_IDLE;
        end else if (lock_ok) begin
          state_next = txkmc_pkg::TXKMC_KEYED;
        end
      end
      txkmc_pkg::TXKMC_KEYED: begin
        if (!tx_req) begin
          state_next = txkmc_pkg::TXKMC_IDLE;
        end else if (!lock_ok) begin
          state_next = txkmc_pkg::TXKMC_WAIT_LOCK;
        end
      end
      default: begin
        state_next = txkmc_pkg::TXKMC_IDLE;
      end
    endcase
  end

  wire key_next = (state_next == txkmc_pkg::TXKMC_KEYED);
  wire osc_next = (state_next != txkmc_pkg::TXKMC_IDLE);

  // Registered station outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= txkmc_pkg::TXKMC_IDLE;
      amplifier_keying <= 1'b0;
      antenna_switch_drive <= 1'b0;
      synth_osc_power <= 1'b0;
      intercom_mode <= 1'b0;
      rx_unmute <= 1'b0;
      repeat_active <= 1'b0;
      tx_led <= 1'b0;
      monitor_led <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      amplifier_keying <= key_next;
      antenna_switch_drive <= osc_next;
      synth_osc_power <= osc_next;
      intercom_mode <= tx_disabled;
      rx_unmute <= unmute_next;
      repeat_active <= repeat_next & key_next;
      tx_led <= key_next;
      monitor_led <= monitor;
    end
  end

  // ----------------------------------------------------------------
  // Fault status on serial bus
  // ----------------------------------------------------------------
  txkmc_ser_if ser_bus ();
  assign ser_bus.sclk = serial_clk;
  assign ser_bus.sdata = serial_data;
  assign ser_bus.enable = serial_enable;
  assign ser_bus.addr = serial_addr;
  assign ser_bus.flags = rf_fault_flags;

  txkmc_status_ser u_status_ser (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .bus(ser_bus.ser)
  );
  assign rf_fault_status_out = ser_bus.status_bit;

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  logic key_d_reg;
  logic lock_d_reg;
  logic [4:0] flags_d_reg;
  wire [2:0] ev;

  // Local flag sync for fault events and status readback
  always_ff @(posedge clk) begin
    if (rst) begin
      key_d_reg <= 1'b0;
      lock_d_reg <= 1'b0;
      flags_m_reg <= 5'h00;
      flags_s_reg <= 5'h00;
      flags_d_reg <= 5'h00;
    end else if (ce) begin
      key_d_reg <= amplifier_keying;
      lock_d_reg <= lock_ok;
      flags_m_reg <= rf_fault_flags;
      flags_s_reg <= flags_m_reg;
      flags_d_reg <= flags_s_reg; // Edge history, keeps the first stage private
    end
  end

  // Event decode
  assign ev[txkmc_pkg::IRQ_KEY_ON] = amplifier_keying & ~key_d_reg;
  assign ev[txkmc_pkg::IRQ_LOCK_LOST] = lock_d_reg & ~lock_ok & osc_next;
  assign ev[txkmc_pkg::IRQ_FAULT] = |(flags_s_reg & ~flags_d_reg);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  wire wr_ctrl = reg_wr & (reg_addr == txkmc_pkg::CTRL_OFS);
  wire wr_int = reg_wr & (reg_addr == txkmc_pkg::INT_STAT_OFS);
  wire wr_mask = reg_wr & (reg_addr == txkmc_pkg::INT_MASK_OFS);
  wire [2:0] w1c = wr_int ? reg_wdata[2:0] : 3'h0;

  assign status_word = {19'h0, flags_s_reg, 2'h0, rx_unmute, intercom_mode, monitor,
                        lock_ok, antenna_switch_drive, amplifier_keying};

  // Read mux, zero for unmapped
  wire [31:0] rd_mux =
    (reg_addr == txkmc_pkg::CTRL_OFS) ? {29'h0, ctrl_reg} :
    (reg_addr == txkmc_pkg::STAT_OFS) ? status_word :
    (reg_addr == txkmc_pkg::INT_STAT_OFS) ? {29'h0, int_stat_reg} :
    (reg_addr == txkmc_pkg::INT_MASK_OFS) ? {29'h0, int_mask_reg} : 32'h0;

  // Writes, sticky status with set winning over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= txkmc_pkg::CTRL_RESET;
      int_stat_reg <= 3'h0;
      int_mask_reg <= txkmc_pkg::IRQ_MASK_RESET;
      rdata_reg <= 32'h0;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata[2:0];
      end
      if (wr_mask) begin
        int_mask_reg <= reg_wdata[2:0];
      end
      int_stat_reg <= (int_stat_reg & ~w1c) | ev;
      rdata_reg <= reg_rd ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq = |(int_stat_reg & int_mask_reg);

endmodule // txkmc_top

// ---- txkmc_pkg.sv ----
/*
  Package of constants for transmit keying and mode control.
  Assumes a single 10 MHz clock and a plain register port.
*/
// Overview of operation
// - Transmit-disable switch drops amplifier keying and antenna relay, whatever talk requests exist.
// - While transmission is disabled the station runs in intercom mode.
// - Panel remote talk switch acts exactly like a remote talk command.
// - Monitor mode removes tone qualification from receiver unmuting.
// - Repeating through the transmitter always needs a valid squelch tone.
// - Outside monitor mode, unmuting and repeating both need a valid squelch tone.
// - Amplifier keying output turns the power amplifier on when high, off when low.
// - Amplifier keying never rises unless the synthesizer reports lock.
// - Synthesizer oscillator powered only while transmission is requested and not disabled, from before keying while waiting for lock.
// - Five module fault flags, numbered 0 to 4, collected as status.
// - Fault status is sent over the synthesizer load serial bus.
// - Transmit LED lit whenever the transmitter is on.
// - Monitor LED lit whenever the station is in monitor mode.
// - Serial load uses enable pulse, serial clock and serial data from system module.
// - Three address lines select the serial load target.
package txkmc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int DEBOUNCE_US = 10_000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int DB_CNT_W = 17;

  // ----------------------------------------------------------------
  // Widths and serial bus
  // ----------------------------------------------------------------
  localparam int FLAG_N = 5;
  localparam int ADDR_W = 3;
  localparam logic [2:0] STATUS_ADDR = 3'h7;

  // ----------------------------------------------------------------
  // Register offsets (bytes)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] INT_STAT_OFS = 8'h08;
  localparam logic [7:0] INT_MASK_OFS = 8'h0c;

  // Control fields
  localparam int CTRL_SOFT_DIS = 0;
  localparam int CTRL_SOFT_MON = 1;
  localparam int CTRL_REPEAT_EN = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;

  // Status fields
  localparam int STAT_KEY = 0;
  localparam int STAT_RELAY = 1;
  localparam int STAT_LOCK = 2;
  localparam int STAT_MON = 3;
  localparam int STAT_INTERCOM = 4;
  localparam int STAT_UNMUTE = 5;
  localparam int STAT_FLAG_LSB = 8;

  // Interrupt fields
  localparam int IRQ_N = 3;
  localparam int IRQ_KEY_ON = 0;
  localparam int IRQ_LOCK_LOST = 1;
  localparam int IRQ_FAULT = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // Keying state machine, Gray along idle, wait, keyed
  typedef enum logic [1:0] {
    TXKMC_IDLE = 2'b00,
    TXKMC_WAIT_LOCK = 2'b01,
    TXKMC_KEYED = 2'b11
  } txkmc_key_e;

endpackage

// ---- txkmc_ser_if.sv ----
/*
  Interface between keying top and fault status shifter.
  Assumes raw serial bus pins are carried unsynchronised.
*/
`timescale 1ns/10ps
interface txkmc_ser_if;
  logic sclk;
  logic sdata;
  logic enable;
  logic [2:0] addr;
  logic [4:0] flags;
  logic status_bit;
  modport top (output sclk, output sdata, output enable, output addr, output flags,
               input status_bit);
  modport ser (input sclk, input sdata, input enable, input addr, input flags,
               output status_bit);
endinterface // txkmc_ser_if

// ---- txkmc_debounce.sv ----
/*
  Synchroniser and debouncer for panel switches, one per bit.
  Assumes asynchronous inputs and the block clock.
*/
`timescale 1ns/10ps
module txkmc_debounce #(
  parameter int WIDTH = 3,
  parameter int CYCLES = txkmc_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);

  localparam logic [txkmc_pkg::DB_CNT_W-1:0] LAST =
    txkmc_pkg::DB_CNT_W'(CYCLES - 1);

  // Per switch: two-stage sync, then stable-for-CYCLES filter
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_reg;
    logic sync_reg;
    logic clean_reg;
    logic [txkmc_pkg::DB_CNT_W-1:0] cnt_reg;
    wire differs = sync_reg ^ clean_reg;

    always_ff @(posedge clk) begin
      if (rst) begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
      end else if (ce) begin
        meta_reg <= raw[i];
        sync_reg <= meta_reg;
      end
    end

    // Accept new level only after it holds steady
    always_ff @(posedge clk) begin
      if (rst) begin
        cnt_reg <= '0;
        clean_reg <= 1'b0;
      end else if (ce) begin
        if (!differs) begin
          cnt_reg <= '0;
        end else if (cnt_reg == LAST) begin
          cnt_reg <= '0;
          clean_reg <= sync_reg;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
    assign clean[i] = clean_reg;
  end

endmodule // txkmc_debounce

// ---- txkmc_status_ser.sv ----
/*
  Fault status shifter on the synthesizer load serial bus.
  Assumes system module drives clock, enable and address pins.
*/
`timescale 1ns/10ps
module txkmc_status_ser (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  txkmc_ser_if.ser bus
);

  logic [1:0] sclk_s_reg;
  logic [1:0] en_s_reg;
  logic sclk_d_reg;
  logic en_d_reg;
  logic [2:0] a_m_reg;
  logic [2:0] a_s_reg;
  logic [4:0] f_m_reg;
  logic [4:0] f_s_reg;
  logic [4:0] sh_reg;

  // Two-stage sync of serial clock, enable, address and flags; serial data pin unused
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_s_reg <= 2'h0;
      en_s_reg <= 2'h0;
      a_m_reg <= 3'h0;
      a_s_reg <= 3'h0;
      f_m_reg <= 5'h00;
      f_s_reg <= 5'h00;
      sclk_d_reg <= 1'b0;
      en_d_reg <= 1'b0;
    end else if (ce) begin
      sclk_s_reg <= {sclk_s_reg[0], bus.sclk};
      en_s_reg <= {en_s_reg[0], bus.enable};
      a_m_reg <= bus.addr;
      a_s_reg <= a_m_reg;
      f_m_reg <= bus.flags;
      f_s_reg <= f_m_reg;
      sclk_d_reg <= sclk_s_reg[1];
      en_d_reg <= en_s_reg[1];
    end
  end

  // Edge decode on synchronised levels
  wire en_rise = en_s_reg[1] & ~en_d_reg;
  wire sel = (a_s_reg == txkmc_pkg::STATUS_ADDR);
  wire sclk_rise = sclk_s_reg[1] & ~sclk_d_reg;

  // Load flags on addressed enable, shift out on serial clock
  always_ff @(posedge clk) begin
    if (rst) begin
      sh_reg <= 5'h00;
    end else if (ce) begin
      if (en_rise && sel) begin
        sh_reg <= f_s_reg;
      end else if (sclk_rise) begin
        sh_reg <= {sh_reg[3:0], 1'b0};
      end
    end
  end

  assign bus.status_bit = sh_reg[4];

endmodule // txkmc_status_ser

// ---- txkmc_properties.sv ----
/*
  Checker for the keying top outputs, bound to txkmc_top.
  Assumes one clock domain with synchronous active-high reset.
*/
`timescale 1ns/10ps
module txkmc_checker #(
  parameter int DEBOUNCE_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tx_disable_switch,
  input wire logic carrier_detect,
  input wire logic tone_valid,
  input wire logic synth_lock,
  input wire logic amplifier_keying,
  input wire logic antenna_switch_drive,
  input wire logic synth_osc_power,
  input wire logic intercom_mode,
  input wire logic rx_unmute,
  input wire logic repeat_active,
  input wire logic tx_led,
  input wire logic irq,
  input wire logic rf_fault_status_out
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] dis_cnt;
  logic dis_held;

  // Cycles the disable switch has stood high
  always_ff @(posedge clk) begin
    if (rst || !tx_disable_switch) begin
      dis_cnt <= 8'h0;
    end else if (ce && dis_cnt != 8'hff) begin
      dis_cnt <= dis_cnt + 8'h1;
    end
  end
  assign dis_held = int'(dis_cnt) > DEBOUNCE_CYCLES + 8;

  a_disable_blocks_tx: assert property (
    dis_held |-> !amplifier_keying && !antenna_switch_drive && intercom_mode)
    else $error("keying or relay active while disabled");
  a_intercom_no_osc: assert property (
    intercom_mode && $past(intercom_mode) |-> !synth_osc_power && !amplifier_keying)
    else $error("transmitting in intercom mode");
  a_key_needs_lock: assert property (
    $rose(amplifier_keying) |-> $past(synth_lock, 2) || $past(synth_lock, 3))
    else $error("keying rose without lock");
  a_relay_with_key: assert property (
    amplifier_keying |-> antenna_switch_drive)
    else $error("relay off while keyed");
  a_led_follows_key: assert property (
    tx_led == amplifier_keying)
    else $error("transmit led differs from keying");
  a_osc_pairs_relay: assert property (
    antenna_switch_drive == synth_osc_power)
    else $error("oscillator power differs from relay");
  a_unmute_needs_carrier: assert property (
    rx_unmute |-> $past(carrier_detect, 2) || $past(carrier_detect, 3))
    else $error("unmute without carrier");
  a_repeat_needs_tone: assert property (
    repeat_active |-> amplifier_keying && ($past(tone_valid, 3) || $past(tone_valid, 4)))
    else $error("repeat without tone or keying");

  c_key_rise: cover property ($rose(amplifier_keying));
  c_repeat: cover property (repeat_active);
  c_irq: cover property (irq);
  c_status: cover property (rf_fault_status_out);
endmodule // txkmc_checker

bind txkmc_top txkmc_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) txkmc_checker_i (
  .clk(clk), .rst(rst), .ce(ce), .tx_disable_switch(tx_disable_switch),
  .carrier_detect(carrier_detect), .tone_valid(tone_valid), .synth_lock(synth_lock),
  .amplifier_keying(amplifier_keying), .antenna_switch_drive(antenna_switch_drive),
  .synth_osc_power(synth_osc_power), .intercom_mode(intercom_mode),
  .rx_unmute(rx_unmute), .repeat_active(repeat_active), .tx_led(tx_led), .irq(irq),
  .rf_fault_status_out(rf_fault_status_out));

// ---- txkmc_rf_model.sv ----
/*
  Transmit synthesizer model: reports lock after warm-up.
  Assumes the oscillator power pin of the keying top.
*/
`timescale 1ns/10ps
module txkmc_rf_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic synth_osc_power,
  input wire logic hold_unlock,
  input wire logic [3:0] lock_delay,
  output logic synth_lock
);
  // ----------------------------------------------------------------
  // Warm-up and lock
  // ----------------------------------------------------------------
  logic [3:0] warm_cnt;

  // Unpowered oscillator restarts its warm-up
  always_ff @(posedge clk) begin
    if (rst || !synth_osc_power) begin
      warm_cnt <= 4'h0;
    end else if (warm_cnt != 4'hf) begin
      warm_cnt <= warm_cnt + 4'h1;
    end
  end
  // Lock only while powered and warmed up
  assign synth_lock = synth_osc_power && !hold_unlock && warm_cnt >= lock_delay;
endmodule // txkmc_rf_model

// ---- tx_keying_mode_control_tb.sv ----
/*
  Self-checking bench for the keying top with a synthesizer model.
  Assumes DEBOUNCE_CYCLES of 4 and a 10 MHz clock.
*/
`timescale 1ns/10ps
module tx_keying_mode_control_tb;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  localparam int DBC = 4;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, tx_disable_switch = 1'b0;
  logic panel_remote_talk_switch = 1'b0, tone_squelch_bypass = 1'b0, local_talk_n = 1'b1;
  logic remote_talk_cmd = 1'b0, carrier_detect = 1'b0, tone_valid = 1'b0, synth_lock;
  logic [4:0] rf_fault_flags = 5'h0, f;
  logic serial_clk = 1'b0, serial_data = 1'b0, serial_enable = 1'b0;
  logic [2:0] serial_addr = 3'h0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0, hold_unlock = 1'b0;
  logic [3:0] lock_delay = 4'h1;
  logic amplifier_keying, antenna_switch_drive, synth_osc_power, intercom_mode, rx_unmute;
  logic repeat_active, tx_led, monitor_led, rf_fault_status_out, irq;
  logic [31:0] exp_q[$];
  int error_cnt = 0, n_checks = 0;

  txkmc_top #(.DEBOUNCE_CYCLES(DBC)) txkmc_top_i (.clk(clk), .rst(rst), .ce(ce),
    .tx_disable_switch(tx_disable_switch), .panel_remote_talk_switch(panel_remote_talk_switch),
    .tone_squelch_bypass(tone_squelch_bypass), .local_talk_n(local_talk_n),
    .remote_talk_cmd(remote_talk_cmd), .carrier_detect(carrier_detect), .tone_valid(tone_valid),
    .synth_lock(synth_lock), .rf_fault_flags(rf_fault_flags), .serial_clk(serial_clk),
    .serial_data(serial_data), .serial_enable(serial_enable), .serial_addr(serial_addr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .amplifier_keying(amplifier_keying),
    .antenna_switch_drive(antenna_switch_drive), .synth_osc_power(synth_osc_power),
    .intercom_mode(intercom_mode), .rx_unmute(rx_unmute), .repeat_active(repeat_active),
    .tx_led(tx_led), .monitor_led(monitor_led), .rf_fault_status_out(rf_fault_status_out),
    .irq(irq));
  txkmc_rf_model txkmc_rf_model_i (.clk(clk), .rst(rst), .synth_osc_power(synth_osc_power),
    .hold_unlock(hold_unlock), .lock_delay(lock_delay), .synth_lock(synth_lock));

  // Clock of 100 ns period
  initial begin
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic settle();
    repeat (30) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wait_key(input logic v);
    int n;
    for (n = 0; n < 60 && amplifier_keying !== v; n++) @(negedge clk);
    if (amplifier_keying !== v) begin
      error_cnt++;
      $display("ERROR %0t: keying wait expired", $time);
      conclude();
    end
  endtask
  task automatic frame(input logic [2:0] a, input logic [4:0] e);
    int i;
    @(posedge clk);
    serial_addr <= a;
    repeat (8) @(posedge clk);
    serial_enable <= 1'b1;
    repeat (8) @(posedge clk);
    for (i = 4; i >= 0; i--) begin
      @(negedge clk);
      check(rf_fault_status_out, e[i]);
      @(posedge clk);
      serial_clk <= 1'b1;
      repeat (8) @(posedge clk);
      serial_clk <= 1'b0;
      repeat (8) @(posedge clk);
    end
    serial_enable <= 1'b0;
  endtask

  // Read results compared with the oldest note
  always @(posedge clk) begin
    if (rd_q) begin
      check(reg_rdata, exp_q.pop_front());
    end
    rd_q <= reg_rd;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(46));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h4);
    wr(8'h10, 32'hffffffff);
    rd(8'h10, 32'h0);
    rd(8'h0c, 32'h0);
    wr(8'h00, 32'h7);
    rd(8'h00, 32'h7);
    rd(8'h04, 32'h18);
    @(negedge clk);
    check(intercom_mode, 1'b1);
    check(monitor_led, 1'b1);
    wr(8'h00, 32'h4);
    $display("Test done: registers");
    remote_talk_cmd <= 1'b1;
    wait_key(1'b1);
    check(tx_led, 1'b1);
    check(antenna_switch_drive, 1'b1);
    check(synth_osc_power, 1'b1);
    rd(8'h04, 32'h7);
    @(negedge clk);
    check(irq, 1'b0);
    wr(8'h0c, 32'h1);
    @(negedge clk);
    check(irq, 1'b1);
    wr(8'h0c, 32'h0);
    @(negedge clk);
    check(irq, 1'b0);
    wr(8'h0c, 32'h1);
    wr(8'h08, 32'h1);
    @(negedge clk);
    check(irq, 1'b0);
    $display("Test done: remote keying and interrupt");
    @(posedge clk);
    tx_disable_switch <= 1'b1;
    settle();
    check(amplifier_keying, 1'b0);
    check(antenna_switch_drive, 1'b0);
    check(synth_osc_power, 1'b0);
    check(intercom_mode, 1'b1);
    rd(8'h04, 32'h10);
    @(posedge clk);
    tx_disable_switch <= 1'b0;
    remote_talk_cmd <= 1'b0;
    panel_remote_talk_switch <= 1'b1;
    wait_key(1'b1);
    check(intercom_mode, 1'b0);
    @(posedge clk);
    tx_disable_switch <= 1'b1;
    repeat (2) @(posedge clk);
    tx_disable_switch <= 1'b0;
    settle();
    check(amplifier_keying, 1'b1);
    @(posedge clk);
    panel_remote_talk_switch <= 1'b0;
    wait_key(1'b0);
    $display("Test done: disable and panel talk");
    @(posedge clk);
    hold_unlock <= 1'b1;
    lock_delay <= 4'hc;
    local_talk_n <= 1'b0;
    settle();
    check(synth_osc_power, 1'b1);
    check(amplifier_keying, 1'b0);
    @(posedge clk);
    hold_unlock <= 1'b0;
    wait_key(1'b1);
    @(posedge clk);
    hold_unlock <= 1'b1;
    wait_key(1'b0);
    check(synth_osc_power, 1'b1);
    @(posedge clk);
    hold_unlock <= 1'b0;
    wait_key(1'b1);
    @(posedge clk);
    local_talk_n <= 1'b1;
    lock_delay <= 4'h1;
    wait_key(1'b0);
    $display("Test done: lock gating");
    @(posedge clk);
    carrier_detect <= 1'b1;
    settle();
    check(rx_unmute, 1'b0);
    @(posedge clk);
    tone_squelch_bypass <= 1'b1;
    settle();
    check(rx_unmute, 1'b1);
    check(monitor_led, 1'b1);
    check(amplifier_keying, 1'b0);
    rd(8'h04, 32'h28);
    @(posedge clk);
    tone_valid <= 1'b1;
    wait_key(1'b1);
    check(repeat_active, 1'b1);
    @(posedge clk);
    carrier_detect <= 1'b0;
    tone_valid <= 1'b0;
    tone_squelch_bypass <= 1'b0;
    wait_key(1'b0);
    $display("Test done: monitor and repeat");
    f = 5'($urandom()) | 5'h10; // Flag 4 set so a stray load shows
    @(posedge clk);
    rf_fault_flags <= f;
    settle();
    rd(8'h04, {19'h0, f, 8'h0});
    rd(8'h08, 32'h7);
    frame(3'h7, f);
    frame(3'($urandom_range(6, 0)), 5'h0);
    repeat (3) @(posedge clk);
    $display("Test done: fault status");
    conclude();
  end
endmodule // tx_keying_mode_control_tb
